// [rtl/baseband_txrx_config_regs.sv]
// Operation
// - Short mode loads short length register unless test bit set
// - Two ramp symbols added to preamble
// - Long register for long or test
// - Mode bit picks long or short
// - Signal bit four picks filter set
// - Rate field selects code and modulation
// - Length field from high, low bytes
// - CCA mode combines energy, carrier, quality
// - Raw CCA follows, sampled once per slot
// - Sample point 18.7 or 15.8 us
// - Test mode sends alternating or ones
// - Transmit antenna fixed or last good
// - Bit zero disables cover code
// - AGC freeze holds gain in packet
// - Estimate clocks gated, continuous overrides
// - Equalizers bypassed when bit set
// - Data ready after CRC or SFD
// - Slot diversity stops in last half
// - Single antenna acquisition uses choice bit
`include "bb_txrx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module baseband_txrx_config_regs
    import bb_txrx_pkg::*;
#(
    parameter int SLOT_CYCLES = `SLOT_CYC,
    parameter int LATE_CYCLES = `SAMPLE_LATE_CYC,
    parameter int EARLY_CYCLES = `SAMPLE_EARLY_CYC
)(
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Transmit side
    input wire logic transmit_enable_input_i,
    input wire logic symbol_tick_i,
    input wire logic chip_tick_i,
    output logic preamble_active_o,
    output logic [8:0] preamble_count_o,
    output logic short_header_o,
    output rate_e tx_rate_o,
    output logic [7:0] tx_service_o,
    output logic [15:0] tx_length_o,
    output logic japan_weights_o,
    output logic cover_code_en_o,
    output logic tx_test_active_o,
    output logic tx_test_chip_o,
    // Channel assessment
    input wire logic energy_detect_i,
    input wire logic carrier_sense_flag_i,
    input wire logic signal_quality_flag_i,
    output logic cca_o,
    // Antenna
    input wire logic rx_header_crc_ok_i,
    input wire logic rx_antenna_i,
    input wire logic rx_diversity_antenna_i,
    output logic antenna_select_pin_o,
    // Receive side
    input wire logic rx_in_packet_i,
    input wire logic rx_detect_i,
    input wire logic rx_sfd_i,
    input wire logic rx_end_i,
    output logic agc_hold_o,
    output logic est_clk_en_o,
    output logic rx_clk_continuous_o,
    output logic isi_eq_en_o,
    output logic ici_eq_en_o,
    output logic rx_data_ready_out_o
);

    // ****************************************
    // Register bank
    // ****************************************
    logic [7:0] cfg_q [`NUM_REGS]; // Stored configuration bytes

    // Map an address onto a bank index
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        case (addr)
            `ADDR_SHORT_PRE: reg_index = `IDX_SHORT_PRE;
            `ADDR_LONG_PRE: reg_index = `IDX_LONG_PRE;
            `ADDR_SIGNAL: reg_index = `IDX_SIGNAL;
            `ADDR_SERVICE: reg_index = `IDX_SERVICE;
            `ADDR_LEN_HI: reg_index = `IDX_LEN_HI;
            `ADDR_LEN_LO: reg_index = `IDX_LEN_LO;
            `ADDR_TX_CFG: reg_index = `IDX_TX_CFG;
            `ADDR_RX_CFG: reg_index = `IDX_RX_CFG;
            `ADDR_RXTX_CFG: reg_index = `IDX_RXTX_CFG;
            default: reg_index = `IDX_NONE;
        endcase
    endfunction

    // One storage byte per register; all bits kept
    for (genvar g = 0; g < `NUM_REGS; g++)
    begin : g_reg
        always_ff @(posedge core_clk_i or posedge rst_i)
        begin
            if (rst_i)
                cfg_q[g] <= `REG_RESET;
            else if (ce_i && reg_wr_i && reg_index(reg_addr_i) == 4'(g))
                cfg_q[g] <= reg_wdata_i;
        end
    end

    // Read data, zero for unmapped addresses
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= `REG_RESET;
        else if (ce_i && reg_rd_i)
        begin
            if (reg_index(reg_addr_i) == `IDX_NONE)
                reg_rdata_o <= `REG_RESET;
            else
                reg_rdata_o <= cfg_q[reg_index(reg_addr_i)];
        end
    end

    // Field views
    logic [7:0] sig_w; // Signal field byte
    logic [7:0] txc_w; // Transmit configure byte
    logic [7:0] rxc_w; // Receive configure byte
    logic [7:0] rtc_w; // Shared configure byte
    logic use_long_w; // Long length register in use
    logic [8:0] pre_len_w; // Symbols incl. ramp
    logic cca_raw_w; // Combined assessment
    logic tx_edge_w; // Transmit enable rising
    logic tx_en_q; // Delayed transmit enable
    assign sig_w = cfg_q[`IDX_SIGNAL];
    assign txc_w = cfg_q[`IDX_TX_CFG];
    assign rxc_w = cfg_q[`IDX_RX_CFG];
    assign rtc_w = cfg_q[`IDX_RXTX_CFG];
    assign use_long_w = !sig_w[`SIG_SHORT] || rtc_w[`RT_SHORT_TEST];
    assign pre_len_w = {1'b0, use_long_w ? cfg_q[`IDX_LONG_PRE] : cfg_q[`IDX_SHORT_PRE]} + `PA_RAMP_SYMBOLS;
    assign tx_edge_w = transmit_enable_input_i && !tx_en_q;

    // ****************************************
    // Preamble sequencer
    // ****************************************
    pre_state_e pre_state_q; // Sequencer state

    // Load on transmit start, count down per symbol
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_state_q <= PRE_IDLE;
            preamble_count_o <= 9'h000;
            preamble_active_o <= 1'b0;
            tx_en_q <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_en_q <= transmit_enable_input_i;
            case (pre_state_q)
                PRE_IDLE:
                    if (tx_edge_w)
                    begin
                        preamble_count_o <= pre_len_w;
                        preamble_active_o <= 1'b1;
                        pre_state_q <= PRE_RUN;
                    end
                PRE_RUN:
                    // Enable dropped mid preamble: abandon the count
                    if (!transmit_enable_input_i)
                    begin
                        pre_state_q <= PRE_IDLE;
                        preamble_active_o <= 1'b0;
                    end
                    else if (symbol_tick_i)
                    begin
                        preamble_count_o <= preamble_count_o - 9'h001;
                        if (preamble_count_o == 9'h001)
                        begin
                            pre_state_q <= PRE_DONE;
                            preamble_active_o <= 1'b0;
                        end
                    end
                PRE_DONE:
                    if (!transmit_enable_input_i)
                        pre_state_q <= PRE_IDLE;
                default:
                begin
                    pre_state_q <= PRE_IDLE;
                    preamble_active_o <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Transmit header and modes
    // ****************************************
    // Registered copies of the transmit fields
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            short_header_o <= 1'b0;
            tx_rate_o <= RATE_1M_DBPSK;
            tx_service_o <= `REG_RESET;
            tx_length_o <= 16'h0000;
            japan_weights_o <= 1'b0;
            cover_code_en_o <= 1'b0;
            tx_test_active_o <= 1'b0;
        end
        else if (ce_i)
        begin
            short_header_o <= !use_long_w;
            tx_rate_o <= rate_e'(sig_w[1:0]);
            tx_service_o <= cfg_q[`IDX_SERVICE];
            tx_length_o <= {cfg_q[`IDX_LEN_HI], cfg_q[`IDX_LEN_LO]};
            japan_weights_o <= sig_w[`SIG_JAPAN];
            cover_code_en_o <= !txc_w[`TX_COVER_DIS];
            tx_test_active_o <= txc_w[`TX_TEST_EN];
        end
    end

    // Test chip stream: alternating or constant ones
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            tx_test_chip_o <= 1'b0;
        else if (ce_i && txc_w[`TX_TEST_EN])
        begin
            if (txc_w[`TX_TEST_SEL])
                tx_test_chip_o <= 1'b1;
            else if (chip_tick_i)
                tx_test_chip_o <= !tx_test_chip_o;
        end
    end

    // ****************************************
    // Channel assessment
    // ****************************************
    logic [11:0] slot_cnt_q; // Position inside slot
    logic sample_pt_w; // Sampling instant

    always_comb
    begin
        case (cca_mode_e'(txc_w[`TX_CCA_HI:`TX_CCA_LO]))
            CCA_ENERGY: cca_raw_w = energy_detect_i;
            CCA_CARRIER: cca_raw_w = carrier_sense_flag_i || signal_quality_flag_i;
            CCA_AND: cca_raw_w = energy_detect_i && (carrier_sense_flag_i || signal_quality_flag_i);
            CCA_OR: cca_raw_w = energy_detect_i || carrier_sense_flag_i || signal_quality_flag_i;
            default: cca_raw_w = energy_detect_i;
        endcase
    end

    // Free running slot timer
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            slot_cnt_q <= 12'h000;
        else if (ce_i)
            slot_cnt_q <= (slot_cnt_q == 12'(SLOT_CYCLES - 1)) ? 12'h000 : slot_cnt_q + 12'h001;
    end

    assign sample_pt_w = slot_cnt_q == 12'(txc_w[`TX_SAMPLE_TIME] ? EARLY_CYCLES : LATE_CYCLES);

    // raw follows, sampled once per slot
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cca_o <= 1'b0;
        else if (ce_i && (!rtc_w[`RT_CCA_SAMPLED] || sample_pt_w))
            cca_o <= cca_raw_w;
    end

    // ****************************************
    // Antenna selection
    // ****************************************
    logic last_good_ant_q; // Antenna of last good header

    // Remember antenna of last valid header
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            last_good_ant_q <= 1'b0;
        else if (ce_i && rx_header_crc_ok_i)
            last_good_ant_q <= rx_antenna_i;
    end

    // Drive the select pin for transmit or receive
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            antenna_select_pin_o <= 1'b0;
        else if (ce_i)
        begin
            if (transmit_enable_input_i)
                antenna_select_pin_o <= txc_w[`TX_DIVERSITY] ? last_good_ant_q : txc_w[`TX_ANT_CHOICE];
            else if (rxc_w[`RX_SINGLE])
                antenna_select_pin_o <= rxc_w[`RX_ANT_CHOICE];
            // hold in last half of slot
            else if (!(rxc_w[`RX_SLOT_DIV] && slot_cnt_q >= 12'(SLOT_CYCLES / 2)))
                antenna_select_pin_o <= rx_diversity_antenna_i;
        end
    end

    // ****************************************
    // Receive controls
    // ****************************************
    // Gain hold, clock gating and equalizer enables
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            agc_hold_o <= 1'b0;
            est_clk_en_o <= 1'b0;
            rx_clk_continuous_o <= 1'b0;
            isi_eq_en_o <= 1'b0;
            ici_eq_en_o <= 1'b0;
        end
        else if (ce_i)
        begin
            agc_hold_o <= rxc_w[`RX_AGC_FREEZE] && rx_in_packet_i;
            est_clk_en_o <= rtc_w[`RT_CONT_CLK] || !rxc_w[`RX_EST_CLK] || rx_detect_i;
            rx_clk_continuous_o <= rtc_w[`RT_CONT_CLK];
            isi_eq_en_o <= !rxc_w[`RX_ISI_DIS];
            ici_eq_en_o <= !rxc_w[`RX_ICI_DIS];
        end
    end

    // Data ready: set on chosen event, cleared at frame end; set wins
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rx_data_ready_out_o <= 1'b0;
        else if (ce_i && (rxc_w[`RX_READY_SFD] ? rx_sfd_i : rx_header_crc_ok_i))
            rx_data_ready_out_o <= 1'b1;
        else if (ce_i && rx_end_i)
            rx_data_ready_out_o <= 1'b0;
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence wr_seq;
        ce_i && reg_wr_i && reg_index(reg_addr_i) != `IDX_NONE;
    endsequence
    sequence rd_seq;
        ce_i && reg_rd_i && reg_index(reg_addr_i) != `IDX_NONE;
    endsequence

    preamble_load_a: assert property (ce_i && pre_state_q == PRE_IDLE && tx_edge_w
        |=> preamble_count_o == $past(pre_len_w) && preamble_active_o)
        else $error("preamble count not loaded with ramp");
    long_select_a: assert property (ce_i && pre_state_q == PRE_IDLE && tx_edge_w && rtc_w[`RT_SHORT_TEST]
        |=> preamble_count_o == {1'b0, $past(cfg_q[`IDX_LONG_PRE])} + `PA_RAMP_SYMBOLS)
        else $error("long length not used");
    cca_raw_a: assert property (ce_i && !rtc_w[`RT_CCA_SAMPLED] |=> cca_o == $past(cca_raw_w))
        else $error("raw cca did not follow sources");
    cca_hold_a: assert property (rtc_w[`RT_CCA_SAMPLED] && !sample_pt_w |=> $stable(cca_o))
        else $error("sampled cca changed off sample point");
    sample_time_a: assert property (ce_i && rtc_w[`RT_CCA_SAMPLED] && txc_w[`TX_SAMPLE_TIME]
        && slot_cnt_q == 12'(EARLY_CYCLES) |=> cca_o == $past(cca_raw_w))
        else $error("cca not sampled at early point");
    tx_antenna_a: assert property (ce_i && transmit_enable_input_i && !txc_w[`TX_DIVERSITY]
        |=> antenna_select_pin_o == $past(txc_w[`TX_ANT_CHOICE]))
        else $error("tx antenna not from choice bit");
    eq_enable_a: assert property (ce_i ##1 ce_i |-> isi_eq_en_o == !$past(rxc_w[`RX_ISI_DIS]))
        else $error("isi equalizer enable wrong");
    ready_set_a: assert property (ce_i && rxc_w[`RX_READY_SFD] && rx_sfd_i |=> rx_data_ready_out_o)
        else $error("data ready missed sfd");
    readback_a: assert property (wr_seq |=> cfg_q[$past(reg_index(reg_addr_i))] == $past(reg_wdata_i))
        else $error("written byte not stored");
    read_data_a: assert property (rd_seq |=> reg_rdata_o == $past(cfg_q[reg_index(reg_addr_i)]))
        else $error("read data differs from stored byte");
    slot_hold_a: assert property (ce_i && !transmit_enable_input_i && !rxc_w[`RX_SINGLE]
        && rxc_w[`RX_SLOT_DIV] && slot_cnt_q >= 12'(SLOT_CYCLES / 2) |=> $stable(antenna_select_pin_o))
        else $error("antenna switched in last half of slot");

endmodule

`default_nettype wire

// [rtl/bb_txrx_cfg.svh]
`ifndef BB_TXRX_CFG_SVH
`define BB_TXRX_CFG_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_SHORT_PRE 8'h06
`define ADDR_LONG_PRE 8'h08
`define ADDR_SIGNAL 8'h0a
`define ADDR_SERVICE 8'h0c
`define ADDR_LEN_HI 8'h0e
`define ADDR_LEN_LO 8'h10
`define ADDR_TX_CFG 8'h12
`define ADDR_RX_CFG 8'h14
`define ADDR_RXTX_CFG 8'h16
`define NUM_REGS 9
`define REG_RESET 8'h00

// ****************************************
// Register indices inside the bank
// ****************************************
`define IDX_SHORT_PRE 4'h0
`define IDX_LONG_PRE 4'h1
`define IDX_SIGNAL 4'h2
`define IDX_SERVICE 4'h3
`define IDX_LEN_HI 4'h4
`define IDX_LEN_LO 4'h5
`define IDX_TX_CFG 4'h6
`define IDX_RX_CFG 4'h7
`define IDX_RXTX_CFG 4'h8
`define IDX_NONE 4'hf

// ****************************************
// Field positions
// ****************************************
`define SIG_JAPAN 4
`define SIG_SHORT 3
`define TX_SAMPLE_TIME 7
`define TX_CCA_HI 6
`define TX_CCA_LO 5
`define TX_TEST_SEL 4
`define TX_TEST_EN 3
`define TX_ANT_CHOICE 2
`define TX_DIVERSITY 1
`define TX_COVER_DIS 0
`define RX_AGC_FREEZE 7
`define RX_EST_CLK 6
`define RX_ISI_DIS 5
`define RX_ICI_DIS 4
`define RX_READY_SFD 3
`define RX_SLOT_DIV 2
`define RX_ANT_CHOICE 1
`define RX_SINGLE 0
`define RT_CONT_CLK 7
`define RT_SHORT_TEST 4
`define RT_CCA_SAMPLED 3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define PA_RAMP_SYMBOLS 9'h002
`define SLOT_NS 20000
`define SAMPLE_LATE_NS 18700
`define SAMPLE_EARLY_NS 15800
`define SLOT_CYC (`SLOT_NS / `CLK_PERIOD_NS)
`define SAMPLE_LATE_CYC ((`SAMPLE_LATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_EARLY_CYC ((`SAMPLE_EARLY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/bb_txrx_pkg.sv]
package bb_txrx_pkg;
    // Transmit rate encoding
    typedef enum logic [1:0] {
        RATE_1M_DBPSK = 2'b00,
        RATE_2M_DQPSK = 2'b01,
        RATE_5M5_CCK = 2'b10,
        RATE_11M_CCK = 2'b11
    } rate_e;
    // Channel assessment source selection
    typedef enum logic [1:0] {
        CCA_ENERGY = 2'b00,
        CCA_CARRIER = 2'b01,
        CCA_AND = 2'b10,
        CCA_OR = 2'b11
    } cca_mode_e;
    // Preamble sequencer states
    typedef enum logic [1:0] {
        PRE_IDLE = 2'b00,
        PRE_RUN = 2'b01,
        PRE_DONE = 2'b10
    } pre_state_e;
endpackage

// [testbench/baseband_txrx_config_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module baseband_txrx_config_regs_tb;
    import bb_txrx_pkg::*;
    // Stimulus and observed signals
    logic clk = 1'b0, rst = 1'b1, wr, rd, txen;
    logic [7:0] addr, wdata, rdata, v;
    logic sym = 0, chip = 0, ed = 0, cs = 0, sq = 0, crc = 0, rant = 0;
    logic dant = 0, inpkt = 0, det = 0, sfd = 0, rend = 0, ce = 1;
    logic pact, shdr, japan, cov, tact, tchip, cca, ant, agc, estc, cont, intersymbol_interference, interchip_interference, rdy;
    logic [8:0] pcnt;
    rate_e rate;
    logic [7:0] svc;
    logic [15:0] len;
    logic [7:0] regs [9];
    int mismatches = 0, check_count = 0, seed = 71720, cyc = 0, p0, p1, n;

    mac_model mac_inst (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata), .tx_en_o(txen));

    baseband_txrx_config_regs #(.SLOT_CYCLES(20), .LATE_CYCLES(18), .EARLY_CYCLES(15))
    baseband_txrx_config_regs_inst (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .transmit_enable_input_i(txen), .symbol_tick_i(sym), .chip_tick_i(chip),
        .preamble_active_o(pact), .preamble_count_o(pcnt), .short_header_o(shdr), .tx_rate_o(rate),
        .tx_service_o(svc), .tx_length_o(len), .japan_weights_o(japan), .cover_code_en_o(cov),
        .tx_test_active_o(tact), .tx_test_chip_o(tchip), .energy_detect_i(ed),
        .carrier_sense_flag_i(cs), .signal_quality_flag_i(sq), .cca_o(cca),
        .rx_header_crc_ok_i(crc), .rx_antenna_i(rant), .rx_diversity_antenna_i(dant),
        .antenna_select_pin_o(ant), .rx_in_packet_i(inpkt), .rx_detect_i(det), .rx_sfd_i(sfd),
        .rx_end_i(rend), .agc_hold_o(agc), .est_clk_en_o(estc), .rx_clk_continuous_o(cont),
        .isi_eq_en_o(intersymbol_interference), .ici_eq_en_o(interchip_interference), .rx_data_ready_out_o(rdy));

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // Cycle count, also cuts a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // ****
    // Helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Expected busy flag for a source combination
    function automatic logic cca_f(input logic [1:0] m, input logic e, input logic q);
        return (m == 2'd0) ? e : (m == 2'd1) ? q : (m == 2'd2) ? (e & q) : (e | q);
    endfunction

    // Preamble start and one symbol of countdown
    task automatic pre(input logic [7:0] sig, input logic [7:0] rt, input logic [8:0] exp);
        mac_inst.wr(8'h0a, sig);
        mac_inst.wr(8'h16, rt);
        wait_n(200);
        mac_inst.tx(1'b1);
        wait_n(2);
        chk(16'(pcnt), 16'(exp));
        chk(16'(pact), 16'h0001);
        chk(16'(shdr), 16'(sig[3] & !rt[4]));
        sym = 1'b1;
        @(negedge clk);
        sym = 1'b0;
        chk(16'(pcnt), 16'(exp - 9'h001));
        mac_inst.tx(1'b0);
        wait_n(2);
        chk(16'(pact), 16'h0000);
    endtask

    // Sampled busy: rise seen, then inputs drop; fall comes one slot later
    task automatic meas(output int ph);
        ed = 1'b1;
        n = 0;
        while (cca !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        ed = 1'b0;
        ph = cyc % 20;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (cca === 1'b1 && n < 50);
        chk(16'(n), 16'h0014);
    endtask

    task automatic finish_test();
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial
    begin
        wait_n(6);
        rst = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            regs[i] = $random(seed);
            mac_inst.wr(8'(8'h06 + 2 * i), regs[i]);
        end
        for (int i = 0; i < 9; i++)
        begin
            mac_inst.rd(8'(8'h06 + 2 * i), v);
            chk(16'(v), 16'(regs[i]));
        end
        mac_inst.rd(8'h07, v);
        chk(16'(v), 16'h0000);
        // Header fields for every rate code
        for (int r = 0; r < 4; r++)
        begin
            regs[4] = $random(seed);
            regs[5] = $random(seed);
            mac_inst.wr(8'h0a, 8'(r + 16 * (r % 2)));
            mac_inst.wr(8'h0c, 8'h84);
            mac_inst.wr(8'h0e, regs[4]);
            mac_inst.wr(8'h10, regs[5]);
            mac_inst.wr(8'h12, 8'(r % 2));
            wait_n(3);
            chk(16'(rate), 16'(r));
            chk(16'(japan), 16'(r % 2));
            chk(len, {regs[4], regs[5]});
            chk(16'(cov), 16'(1 - r % 2));
            chk(16'(svc), 16'h0084);
        end
        mac_inst.wr(8'h06, 8'h38);
        mac_inst.wr(8'h08, 8'h80);
        pre(8'h0b, 8'h00, 9'h03a);
        pre(8'h03, 8'h00, 9'h082);
        pre(8'h0b, 8'h10, 9'h082);
        mac_inst.wr(8'h06, 8'hff);
        pre(8'h08, 8'h00, 9'h101);
        // Raw busy flag over all modes
        for (int k = 0; k < 16; k++)
        begin
            mac_inst.wr(8'h12, 8'((k % 4) * 32));
            {ed, cs, sq} = 3'($random(seed));
            wait_n(3);
            chk(16'(cca), 16'(cca_f(2'(k % 4), ed, cs | sq)));
        end
        {ed, cs, sq} = 3'b000;
        mac_inst.wr(8'h12, 8'h00);
        mac_inst.wr(8'h16, 8'h08);
        wait_n(25);
        meas(p0);
        mac_inst.wr(8'h12, 8'h80);
        wait_n(25);
        meas(p1);
        chk(16'((p0 - p1 + 20) % 20), 16'h0003);
        mac_inst.wr(8'h16, 8'h00);
        // Transmit test chips
        mac_inst.wr(8'h12, 8'h18);
        wait_n(3);
        chk(16'({tact, tchip}), 16'h0003);
        mac_inst.wr(8'h12, 8'h08);
        wait_n(3);
        v[0] = tchip;
        chip = 1'b1;
        @(negedge clk);
        chip = 1'b0;
        wait_n(1);
        chk(16'(tchip), 16'(!v[0]));
        // Antenna while transmitting
        mac_inst.tx(1'b1);
        mac_inst.wr(8'h12, 8'h04);
        wait_n(2);
        chk(16'(ant), 16'h0001);
        rant = 1'($random(seed));
        p0 = rant;
        crc = 1'b1;
        @(negedge clk);
        crc = 1'b0;
        rant = !rant;
        mac_inst.wr(8'h12, 8'h02);
        wait_n(2);
        chk(16'(ant), 16'(p0));
        mac_inst.wr(8'h12, 8'h00);
        wait_n(2);
        chk(16'({tact, ant}), 16'h0000);
        mac_inst.tx(1'b0);
        // Antenna while receiving
        for (int k = 0; k < 4; k++)
        begin
            dant = k[0] ^ k[1];
            mac_inst.wr(8'h14, 8'(k[1] ? {k[0], 1'b1} : 2'b00));
            wait_n(2);
            chk(16'(ant), 16'(k[0]));
        end
        // Data ready after delimiter, then after header check
        mac_inst.wr(8'h14, 8'h08);
        rend = 1'b1;
        @(negedge clk);
        rend = 1'b0;
        sfd = 1'b1;
        @(negedge clk);
        sfd = 1'b0;
        wait_n(1);
        chk(16'(rdy), 16'h0001);
        rend = 1'b1;
        mac_inst.wr(8'h14, 8'h00);
        rend = 1'b0;
        sfd = 1'b1;
        @(negedge clk);
        sfd = 1'b0;
        wait_n(1);
        chk(16'(rdy), 16'h0000);
        crc = 1'b1;
        @(negedge clk);
        crc = 1'b0;
        wait_n(1);
        chk(16'(rdy), 16'h0001);
        // Receive controls with random settings
        for (int k = 0; k < 8; k++)
        begin
            v = $random(seed);
            {inpkt, det, dant} = 3'($random(seed));
            mac_inst.wr(8'h14, v & 8'hf4);
            mac_inst.wr(8'h16, {v[0], 7'h00});
            wait_n(3);
            chk(16'(agc), 16'(v[7] & inpkt));
            chk(16'({estc, cont}), 16'({v[0] | !v[6] | det, v[0]}));
            chk(16'({intersymbol_interference, interchip_interference}), 16'({!v[5], !v[4]}));
        end
        // Clock enable low: a write must not land
        for (int k = 0; k < 8; k++)
        begin
            p0 = $random(seed);
            ce = p0[0];
            mac_inst.wr(8'h10, 8'(k + 1));
            ce = 1'b1;
            if (p0[0])
                regs[5] = 8'(k + 1);
            mac_inst.rd(8'h10, v);
            chk(16'(v), 16'(regs[5]));
        end
        finish_test();
    end
endmodule

`default_nettype wire

// [testbench/mac_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****
// Controller stand-in on the register port
// ****
module mac_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i,
    // Transmit
    output logic tx_en_o
);
    // Idle bus at time zero
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        tx_en_o = 1'b0;
    end

    // One-cycle write strobe, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wait (!((a == 8'h06 || a == 8'h08) && tx_en_o));
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    // Read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask

    // Transmit enable level, changed off the sampling edge
    task automatic tx(input logic b);
        @(negedge clk_i);
        tx_en_o = b;
    endtask
endmodule

`default_nettype wire
